/* File: bcg_params.svh */
/*
  Constants for the bus check-code generation unit: polynomials, reset
  values, block sizes for the switch channel check code.
  Assumes it is included by bare name from the design modules.
*/
`ifndef BCG_PARAMS_SVH
`define BCG_PARAMS_SVH
`define BCG_POLY8 8'h8C
`define BCG_POLY16 16'hA001
`define BCG_CRC8_RESET 8'h00
`define BCG_CRC16_RESET 16'h0000
`define BCG_STATUS_PAGE 8'h08
`define BCG_BLK_8 6'h08
`define BCG_BLK_32 6'h20
`define BCG_BITS_PER_BYTE 4'h8
`endif

/* File: bcg_pkg.sv */
/*
  Types for the bus check-code generation unit.
  Assumes bcg_params.svh is reachable by bare name.
*/
package bcg_pkg;
  // Generator operation chosen by the unit's operation select
  typedef enum logic [2:0] {
    BCG_OP_NONE = 3'h0,
    BCG_OP_CLEAR = 3'h1,
    BCG_OP_SHIFT = 3'h2,
    BCG_OP_CLEAR_SHIFT = 3'h3,
    BCG_OP_LOAD = 3'h4
  } bcg_op_t;
  // Channel check-code selection
  typedef enum logic [1:0] {
    BCG_SEL_NONE = 2'h0,
    BCG_SEL_EVERY = 2'h1,
    BCG_SEL_8 = 2'h2,
    BCG_SEL_32 = 2'h3
  } bcg_sel_t;
  // Flow of the current command
  typedef enum logic [2:0] {
    BCG_FLOW_IDLE = 3'h0,
    BCG_FLOW_MEMRD = 3'h1,
    BCG_FLOW_STATRD = 3'h3,
    BCG_FLOW_EXTRD = 3'h2,
    BCG_FLOW_WRITE = 3'h6,
    BCG_FLOW_CHAN = 3'h7
  } bcg_flow_t;
endpackage : bcg_pkg

/* File: bcg_shift.sv */
/*
  Bitwise check-code shifter: 8-bit and 16-bit generators, one byte per call,
  fed least significant bit first. Registered result.
  Assumes the caller presents at most one operation per clock.
*/
`timescale 1ns/1ps
`include "bcg_params.svh"
module bcg_shift
  import bcg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire bcg_op_t op,
  input wire logic [7:0] data_byte,
  input wire logic [15:0] load_value,
  output logic [15:0] crc16,
  output logic [7:0] crc8
);
  function automatic logic [15:0] step16(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = ((r[0] ^ d[i]) != 1'b0) ? ((r >> 1) ^ `BCG_POLY16) : (r >> 1);
    end
    return r;
  endfunction : step16

  function automatic logic [7:0] step8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = ((r[0] ^ d[i]) != 1'b0) ? ((r >> 1) ^ `BCG_POLY8) : (r >> 1);
    end
    return r;
  endfunction : step8

  // Generator update per operation
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      crc16 <= `BCG_CRC16_RESET;
      crc8 <= `BCG_CRC8_RESET;
    end else begin
      unique case (op)
        BCG_OP_NONE: begin
          crc16 <= crc16;
          crc8 <= crc8;
        end
        BCG_OP_CLEAR: begin
          crc16 <= `BCG_CRC16_RESET;
          crc8 <= `BCG_CRC8_RESET;
        end
        BCG_OP_SHIFT: begin
          crc16 <= step16(crc16, data_byte);
          crc8 <= step8(crc8, data_byte);
        end
        BCG_OP_CLEAR_SHIFT: begin
          crc16 <= step16(`BCG_CRC16_RESET, data_byte);
          crc8 <= step8(`BCG_CRC8_RESET, data_byte);
        end
        BCG_OP_LOAD: begin
          crc16 <= load_value;
          crc8 <= crc8;
        end
        default: begin
          crc16 <= crc16;
          crc8 <= crc8;
        end
      endcase
    end
  end
endmodule : bcg_shift

/* File: bcg_unit.sv */
/*
  Check-code sequencing for the addressable switch: decides when the
  generator clears, loads or shifts for each command flow and when a code
  byte pair is due. The byte sequencer presents each bus byte with a strobe.
  Assumes all inputs come from logic on ref_clk; no pins enter here.
*/
`timescale 1ns/1ps
`include "bcg_params.svh"
module bcg_unit
  import bcg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire bcg_flow_t flow,
  input wire logic start,
  input wire logic byte_stb,
  input wire logic [7:0] byte_data,
  input wire logic header_byte,
  input wire logic redir_byte,
  input wire logic page_start,
  input wire logic last_byte,
  input wire logic write_next,
  input wire logic [15:0] next_addr,
  input wire bcg_sel_t chan_sel,
  input wire logic rom_stb,
  output logic code_due,
  output logic [15:0] code16,
  output logic [7:0] code8
);
  bcg_op_t op;
  logic [15:0] crc16;
  logic [7:0] crc8;
  logic [5:0] chan_cnt;
  logic first_pass;
  logic load_pend;
  logic [7:0] pend_byte;
  logic chan_hit;
  logic [5:0] blk;

  // Block length for channel traffic
  function automatic logic [5:0] blk_len(input bcg_sel_t s);
    unique case (s)
      BCG_SEL_EVERY: return 6'h01;
      BCG_SEL_8: return `BCG_BLK_8;
      BCG_SEL_32: return `BCG_BLK_32;
      default: return 6'h00;
    endcase
  endfunction : blk_len

  assign blk = blk_len(chan_sel);
  assign chan_hit = (flow == BCG_FLOW_CHAN) && byte_stb && !header_byte &&
                    (blk != 6'h00) && (chan_cnt == blk - 6'h01);

  // First-pass flag: header bytes extend the cleared generator
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      first_pass <= 1'b1;
    end else if (start) begin
      first_pass <= 1'b1;
    end else if (code_due) begin
      first_pass <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || start) begin
      chan_cnt <= 6'h00;
    end else if (flow == BCG_FLOW_CHAN && byte_stb && !header_byte) begin
      chan_cnt <= chan_hit ? 6'h00 : chan_cnt + 6'h01;
    end
  end

  // address load followed by data shift one cycle later
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      load_pend <= 1'b0;
      pend_byte <= 8'h00;
    end else begin
      load_pend <= byte_stb && write_next && flow == BCG_FLOW_WRITE;
      pend_byte <= byte_data;
    end
  end

  // Operation select for the generator
  always_comb begin
    op = BCG_OP_NONE;
    if (start) begin
      op = BCG_OP_CLEAR;
    end else if (load_pend) begin
      op = BCG_OP_SHIFT;
    end else if (byte_stb) begin
      unique case (flow)
        BCG_FLOW_WRITE: op = write_next ? BCG_OP_LOAD : BCG_OP_SHIFT;
        // clear on later redirection; page from clear
        BCG_FLOW_EXTRD: op = ((redir_byte && !first_pass) || page_start) ?
                              BCG_OP_CLEAR_SHIFT : BCG_OP_SHIFT;
        BCG_FLOW_CHAN: op = (!header_byte && !first_pass && chan_cnt == 6'h00) ?
                             BCG_OP_CLEAR_SHIFT : BCG_OP_SHIFT;
        default: op = BCG_OP_SHIFT;
      endcase
    end else if (rom_stb) begin
      op = BCG_OP_SHIFT;
    end
  end

  bcg_shift u_shift (
    .ref_clk(ref_clk),
    .rst(rst),
    .op(op),
    .data_byte(load_pend ? pend_byte : byte_data),
    .load_value(next_addr),
    .crc16(crc16),
    .crc8(crc8)
  );

  // Code due marks: last byte, redirection, each write, block
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      code_due <= 1'b0;
    end else begin
      code_due <= (byte_stb && !write_next && (
                   ((flow == BCG_FLOW_MEMRD || flow == BCG_FLOW_STATRD ||
                     flow == BCG_FLOW_EXTRD) && last_byte) ||
                   (flow == BCG_FLOW_EXTRD && redir_byte) ||
                   (flow == BCG_FLOW_WRITE && !header_byte) || chan_hit)) || load_pend;
    end
  end

  assign code16 = ~crc16;
  assign code8 = crc8;
  // nothing here gates the sequence on a mismatch

  // Code due follows a qualifying strobe by one cycle
  sequence last_rd_s;
    byte_stb && last_byte && flow == BCG_FLOW_MEMRD;
  endsequence
  mem_code_due_a: assert property (@(posedge ref_clk) disable iff (rst)
    last_rd_s |=> code_due) else $error("read code not due after last byte");
  // A cleared generator must show as all ones on the complemented output
  out_inverted_a: assert property (@(posedge ref_clk) disable iff (rst)
    start |=> code16 == ~`BCG_CRC16_RESET) else $error("code not complemented");
  rom_true_a: assert property (@(posedge ref_clk) disable iff (rst)
    start |=> code8 == `BCG_CRC8_RESET) else $error("ROM code not in true form");
  start_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    start |=> crc16 == `BCG_CRC16_RESET) else $error("start did not clear");
  wr_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    byte_stb && write_next && flow == BCG_FLOW_WRITE && !start |=> crc16 == $past(next_addr))
    else $error("address not loaded");
  wr_code_a: assert property (@(posedge ref_clk) disable iff (rst)
    byte_stb && flow == BCG_FLOW_WRITE && !header_byte && !write_next |=> code_due)
    else $error("write code missing");
  redir_code_a: assert property (@(posedge ref_clk) disable iff (rst)
    byte_stb && redir_byte && flow == BCG_FLOW_EXTRD |=> code_due)
    else $error("redirection code missing");
  chan_none_a: assert property (@(posedge ref_clk) disable iff (rst)
    flow == BCG_FLOW_CHAN && chan_sel == BCG_SEL_NONE && !load_pend |=> !code_due)
    else $error("code with selection none");

  // Reference steps for the checks below, kept apart from the shifter on purpose
  function automatic logic [15:0] ref16(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = ((r[0] ^ d[i]) != 1'b0) ? ((r >> 1) ^ `BCG_POLY16) : (r >> 1);
    end
    return r;
  endfunction : ref16

  function automatic logic [7:0] ref8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = ((r[0] ^ d[i]) != 1'b0) ? ((r >> 1) ^ `BCG_POLY8) : (r >> 1);
    end
    return r;
  endfunction : ref8

  // Byte kinds that decide between clearing, extending and loading the generator
  sequence first_redir_s;
    byte_stb && redir_byte && flow == BCG_FLOW_EXTRD && first_pass && !page_start &&
    !start && !load_pend;
  endsequence
  sequence later_redir_s;
    byte_stb && redir_byte && flow == BCG_FLOW_EXTRD && !first_pass && !start && !load_pend;
  endsequence
  sequence page_first_s;
    byte_stb && page_start && flow == BCG_FLOW_EXTRD && !start && !load_pend;
  endsequence
  sequence chan_block_s;
    byte_stb && !header_byte && flow == BCG_FLOW_CHAN && !first_pass &&
    chan_cnt == 6'h00 && !start && !load_pend;
  endsequence
  sequence wr_next_s;
    byte_stb && write_next && flow == BCG_FLOW_WRITE && !start && !load_pend;
  endsequence
  sequence wr_gap_s;
    !start;
  endsequence

  // Code due after a status page or an extended page
  stat_code_due_a: assert property (@(posedge ref_clk) disable iff (rst)
    byte_stb && last_byte && flow == BCG_FLOW_STATRD |=> code_due)
    else $error("status code not due after last byte");
  page_code_due_a: assert property (@(posedge ref_clk) disable iff (rst)
    byte_stb && last_byte && flow == BCG_FLOW_EXTRD |=> code_due)
    else $error("page code not due after last byte");
  // A plain read stays quiet until its last byte, headers raise no code unless also last or redirection bytes
  mem_mid_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
    flow == BCG_FLOW_MEMRD && !(byte_stb && last_byte) && !load_pend |=> !code_due)
    else $error("read code before last byte");
  hdr_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
    byte_stb && header_byte && !last_byte && !redir_byte && !load_pend |=> !code_due)
    else $error("code due after a header byte");
  // Clear versus extend, checked against the reference step; then the per-byte channel code due
  first_redir_a: assert property (@(posedge ref_clk) disable iff (rst)
    first_redir_s |=> crc16 == ref16($past(crc16), $past(byte_data)))
    else $error("first redirection did not extend header code");
  redir_fresh_a: assert property (@(posedge ref_clk) disable iff (rst)
    later_redir_s |=> crc16 == ref16(`BCG_CRC16_RESET, $past(byte_data)))
    else $error("later redirection not from clear");
  page_fresh_a: assert property (@(posedge ref_clk) disable iff (rst)
    page_first_s |=> crc16 == ref16(`BCG_CRC16_RESET, $past(byte_data)))
    else $error("page code not from clear");
  chan_fresh_a: assert property (@(posedge ref_clk) disable iff (rst)
    chan_block_s |=> crc16 == ref16(`BCG_CRC16_RESET, $past(byte_data)))
    else $error("channel block not from clear");
  chan_every_a: assert property (@(posedge ref_clk) disable iff (rst)
    byte_stb && !header_byte && !write_next && flow == BCG_FLOW_CHAN &&
    chan_sel == BCG_SEL_EVERY |=> code_due) else $error("per-byte channel code missing");
  // Later write byte: load at the first edge, shift at the second, due at the second as well
  wr_addr_data_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_next_s ##1 wr_gap_s |=> crc16 == ref16($past(next_addr, 2), $past(byte_data, 2)))
    else $error("write code not from loaded address");
  wr_next_due_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_next_s |=> !code_due ##1 code_due) else $error("write code timing wrong");
  // ROM bytes move the 8-bit generator one reference step
  rom_step_a: assert property (@(posedge ref_clk) disable iff (rst)
    rom_stb && !byte_stb && !start && !load_pend |=>
    crc8 == ref8($past(crc8), $past(byte_data))) else $error("ROM code step wrong");
endmodule : bcg_unit

/* File: bcg_master_model.sv */
/*
  Bus master model: keeps its own running check codes over the bytes it sees.
  Assumes the bench gives clear and load cues on the same edge as the strobe.
*/
`timescale 1ns/1ps
module bcg_master_model (
  input wire logic ref_clk,
  input wire logic clr,
  input wire logic ld,
  input wire logic [15:0] ld_val,
  input wire logic stb,
  input wire logic rom,
  input wire logic [7:0] d,
  output logic [15:0] acc16,
  output logic [7:0] acc8
);
  logic [15:0] base;
  function automatic logic [15:0] f16(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction : f16
  function automatic logic [7:0] f8(input logic [7:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
    end
    return c;
  endfunction : f8
  // Clear or load first, so a clearing byte still counts itself
  assign base = clr ? 16'h0000 : (ld ? ld_val : acc16);
  always_ff @(posedge ref_clk) begin
    acc16 <= stb ? f16(base, d) : base;
  end
  // Running ROM code, true form
  always_ff @(posedge ref_clk) begin
    acc8 <= clr ? 8'h00 : (rom ? f8(acc8, d) : acc8);
  end
endmodule : bcg_master_model

/* File: bus_crc_generation_unit_tb.sv */
/*
  Directed bench for the check-code unit, one task per command flow, with memory and status reads sharing t_mem.
  Assumes bcg_unit and bcg_master_model; the master model gives expectations.
*/
`timescale 1ns/1ps
module bus_crc_generation_unit_tb;
  import bcg_pkg::*;
  localparam logic [6:0] RM = 7'h40, HD = 7'h20, RD = 7'h10, PS = 7'h08;
  localparam logic [6:0] LB = 7'h04, WN = 7'h02, CL = 7'h01;
  logic ref_clk, rst, start, byte_stb, header_byte, redir_byte, page_start;
  logic last_byte, write_next, rom_stb, code_due, mclr;
  logic [7:0] byte_data, code8, acc8;
  logic [15:0] next_addr, code16, acc16;
  bcg_flow_t flow;
  bcg_sel_t chan_sel;
  int mismatches = 0;
  int compares = 0;
  // Program pulse stand-in, shortened so that the run stays short
  localparam int PROG_CYC = 8;
  bcg_unit i_dut (.ref_clk(ref_clk), .rst(rst), .flow(flow), .start(start),
    .byte_stb(byte_stb), .byte_data(byte_data), .header_byte(header_byte),
    .redir_byte(redir_byte), .page_start(page_start), .last_byte(last_byte),
    .write_next(write_next), .next_addr(next_addr), .chan_sel(chan_sel),
    .rom_stb(rom_stb), .code_due(code_due), .code16(code16), .code8(code8));
  bcg_master_model i_master (.ref_clk(ref_clk), .clr(mclr), .ld(write_next),
    .ld_val(next_addr), .stb(byte_stb), .rom(rom_stb), .d(byte_data),
    .acc16(acc16), .acc8(acc8));
  // Free-running clock, 4 ns period
  always #2 ref_clk = ~ref_clk;
  task automatic stop_test();
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic go(input bcg_flow_t f, input bcg_sel_t s);
    @(posedge ref_clk) #1;
    flow = f;
    chan_sel = s;
    {start, mclr} = 2'h3;
    @(posedge ref_clk) #1;
    {start, mclr} = 2'h0;
  endtask : go
  // One idle cycle before each byte keeps write spacing and single drives
  task automatic put(input logic [7:0] d, input logic [6:0] k);
    @(posedge ref_clk) #1;
    {rom_stb, header_byte, redir_byte, page_start, last_byte, write_next, mclr} = k;
    byte_stb = ~k[6];
    byte_data = d;
    @(posedge ref_clk) #1;
    {rom_stb, header_byte, redir_byte, page_start, last_byte, write_next, mclr} = 7'h00;
    byte_stb = 1'b0;
  endtask : put
  task automatic due();
    int n = 0;
    while (code_due !== 1'b1 && n < 4) begin
      @(posedge ref_clk) #1;
      n++;
    end
    chk({15'h0, code_due}, 16'h0001);
    chk(code16, ~acc16);
  endtask : due
  task automatic hdr(input int cnt);
    for (int i = 0; i < cnt; i++) put(8'(i * 29 + 15), HD);
  endtask : hdr
  task automatic t_rom();
    for (int i = 0; i < 7; i++) put(8'(i * 37 + 1), RM);
    repeat (2) @(posedge ref_clk) #1;
    chk({8'h00, code8}, {8'h00, acc8});
  endtask : t_rom
  task automatic t_mem();
    go(BCG_FLOW_MEMRD, BCG_SEL_NONE);
    hdr(3);
    put(8'h5a, 7'h00);
    put(8'ha5, LB);
    due();
    go(BCG_FLOW_STATRD, BCG_SEL_NONE);
    hdr(3);
    for (int i = 0; i < 8; i++) put(8'(i * 17), (i == 7) ? LB : 7'h00);
    due();
  endtask : t_mem
  task automatic t_ext();
    go(BCG_FLOW_EXTRD, BCG_SEL_NONE);
    hdr(3);
    put(8'hfe, RD);
    due();
    for (int i = 0; i < 4; i++) put(8'(i + 3), (i == 0) ? (PS | CL) : ((i == 3) ? LB : 7'h00));
    due();
    put(8'hfd, RD | CL);
    due();
  endtask : t_ext
  task automatic t_wr();
    go(BCG_FLOW_WRITE, BCG_SEL_NONE);
    hdr(3);
    put(8'h3c, 7'h00);
    due();
    if (code16 === ~acc16) repeat (PROG_CYC) @(posedge ref_clk) #1;
    chk({15'h0, code_due}, 16'h0000);
    next_addr = 16'h0011;
    put(8'hc3, WN);
    due();
  endtask : t_wr
  // Mid-run reset: outputs return to their cleared values
  task automatic t_rst();
    @(posedge ref_clk) #1;
    {rst, mclr} = 2'h3;
    repeat (2) @(posedge ref_clk) #1;
    {rst, mclr} = 2'h0;
    chk(code16, 16'hffff);
    chk({8'h00, code8}, 16'h0000);
    chk({15'h0, code_due}, 16'h0000);
  endtask : t_rst
  task automatic t_chan();
    int n;
    go(BCG_FLOW_CHAN, BCG_SEL_NONE);
    hdr(4);
    put(8'h77, 7'h00);
    repeat (3) begin
      @(posedge ref_clk) #1;
      chk({15'h0, code_due}, 16'h0000);
    end
    for (int s = 1; s < 4; s++) begin
      n = (s == 1) ? 1 : ((s == 2) ? 8 : 32);
      go(BCG_FLOW_CHAN, bcg_sel_t'(2'(s)));
      hdr(4);
      for (int b = 0; b < 2; b++) begin
        for (int i = 0; i < n; i++) put(8'(b * n + i + 7), (b > 0 && i == 0) ? CL : 7'h00);
        due();
      end
    end
  endtask : t_chan
  // Watchdog well past the roughly 1300 ns the tasks need
  initial begin
    #20000;
    mismatches++;
    stop_test();
  end
  initial begin
    ref_clk = 1'b0;
    {rst, mclr} = 2'h3;
    {start, byte_stb, header_byte, redir_byte, page_start, last_byte} = 6'h00;
    {write_next, rom_stb} = 2'h0;
    byte_data = 8'h00;
    next_addr = 16'h0000;
    flow = BCG_FLOW_IDLE;
    chan_sel = BCG_SEL_NONE;
    repeat (6) @(posedge ref_clk);
    #1 {rst, mclr} = 2'h0;
    t_rom();
    t_mem();
    t_ext();
    t_wr();
    t_rst();
    t_chan();
    stop_test();
  end
endmodule : bus_crc_generation_unit_tb
